// [ess_pkg.sv]
// constants, types and helpers for the sync input qualifier
package ess_pkg;
    // four-bit quality codes
    localparam logic [3:0] ESS_Q_UNKNOWN = 4'h0;
    localparam logic [3:0] ESS_Q_PRC     = 4'h2;
    localparam logic [3:0] ESS_Q_SSUA    = 4'h4;
    localparam logic [3:0] ESS_Q_SSUB    = 4'h8;
    localparam logic [3:0] ESS_Q_ETS     = 4'hb;
    localparam logic [3:0] ESS_Q_DNU     = 4'hf;
    // spare bit numbers and slot 0 layout, bit 1 is the msb
    localparam logic [3:0] ESS_SA_FIRST  = 4'h4;
    localparam logic [3:0] ESS_SA_LAST   = 4'h8;
    localparam logic [3:0] ESS_SA_DEF    = 4'h4;
    localparam logic [1:0] ESS_NFAS_LAST = 2'h3;
    localparam logic [6:0] ESS_FAS_WORD  = 7'h1b;
    localparam logic [4:0] ESS_SA_IDLE   = 5'h1f;
    // frequency input configuration, hertz
    localparam logic [23:0] ESS_FREQ_MIN = 24'h0003e8;
    localparam logic [23:0] ESS_FREQ_MAX = 24'h989680;
    localparam logic [23:0] ESS_FREQ_DEF = 24'h1f4000;
    // slip tolerance in half cycles
    localparam logic [2:0] ESS_SLIP_MIN  = 3'h1;
    localparam logic [2:0] ESS_SLIP_MAX  = 3'h6;
    localparam logic [2:0] ESS_SLIP_DEF  = 3'h3;
    localparam logic [3:0] ESS_MAX_DEF   = 4'h8;
    // clock and measurement gate
    localparam int ESS_CLK_HZ       = 50000000;
    localparam int ESS_GATE_TIME_MS = 1000;
    localparam int ESS_GATE_CYCLES  = ESS_CLK_HZ / 1000 * ESS_GATE_TIME_MS;
    // line output figures
    localparam logic [5:0]  ESS_E1_CHANNELS = 6'h20;
    localparam logic [5:0]  ESS_T1_CHANNELS = 6'h18;
    localparam logic [1:0]  ESS_E1_RSV_CH   = 2'h2;
    localparam logic [1:0]  ESS_T1_RSV_CH   = 2'h0;
    localparam logic [6:0]  ESS_CH_KBPS     = 7'h40;
    localparam logic [11:0] ESS_E1_KBPS     = 12'h800;
    localparam logic [11:0] ESS_T1_KBPS     = 12'h608;

    typedef enum logic [1:0] {
        ESS_HUNT    = 2'b00,
        ESS_COLLECT = 2'b01
    } ess_ext_e;

    // spare bit number to slot 0 byte index
    function automatic logic [2:0] ess_sa_index(input logic [3:0] n);
        logic [3:0] idx;
        idx = 4'h8 - n;
        return idx[2:0];
    endfunction

    function automatic logic ess_is_reserved(input logic [3:0] c);
        return !(c == ESS_Q_UNKNOWN || c == ESS_Q_PRC || c == ESS_Q_SSUA ||
                 c == ESS_Q_SSUB || c == ESS_Q_ETS || c == ESS_Q_DNU);
    endfunction

    function automatic logic [23:0] ess_absdiff(input logic [23:0] a,
                                               input logic [23:0] b);
        return (a > b) ? a - b : b - a;
    endfunction
endpackage

// [ess_ssm_extract.sv]
// collects the quality nibble from the chosen spare bit
`timescale 1ns/10ps
module ess_ssm_extract
    import ess_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       enable,
    input  wire logic [2:0] sa_index,
    input  wire logic       ts0_valid,
    input  wire logic [7:0] ts0_byte,
    input  wire logic       nfas,
    input  wire logic       smf_start,
    output logic [3:0]      code,
    output logic            code_valid
);
    ess_ext_e   state_q, state_d;
    logic [1:0] cnt_q;
    logic [3:0] shift_q;

    // selected spare bit, shifted in msb first
    wire        sa_bit  = ts0_byte[sa_index];
    wire        take    = ts0_valid && nfas && state_q == ESS_COLLECT;
    wire        done    = take && cnt_q == ESS_NFAS_LAST;
    wire        restart = ts0_valid && smf_start;

    // sequence: wait for sub-multiframe, then four non-alignment frames
    always_comb begin
        state_d = state_q;
        case (state_q)
            ESS_HUNT:    if (restart) state_d = ESS_COLLECT;
            ESS_COLLECT: if (restart) state_d = ESS_COLLECT;
                         else if (done) state_d = ESS_HUNT;
            default:     state_d = ESS_HUNT;
        endcase
        if (!enable) state_d = ESS_HUNT;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q    <= ESS_HUNT;
            cnt_q      <= 2'h0;
            shift_q    <= 4'h0;
            code       <= 4'h0;
            code_valid <= 1'b0;
        end else begin
            state_q    <= state_d;
            code_valid <= done && enable;
            if (restart) cnt_q <= 2'h0;
            else if (take) cnt_q <= cnt_q + 2'h1;
            if (take) shift_q <= {shift_q[2:0], sa_bit};
            if (done) code <= {shift_q[2:0], sa_bit};
        end
    end
endmodule

// [ess_ssm_judge.sv]
// classifies the received quality code against the limit
`timescale 1ns/10ps
module ess_ssm_judge
    import ess_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       t1_mode,
    input  wire logic [3:0] code_in,
    input  wire logic       code_valid,
    input  wire logic [3:0] max_code,
    output logic [3:0]      code_q,
    output logic            sync_ok,
    output logic            reserved,
    output logic            equipment_timing_source_level,
    output logic            never_use
);
    logic seen_q;

    // smaller code is better; reserved and never-use codes always fail
    wire rsv    = ess_is_reserved(code_q);
    wire dnu    = code_q == ESS_Q_DNU;
    wire accept = seen_q && !rsv && !dnu && code_q <= max_code;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            code_q   <= ESS_Q_UNKNOWN;
            seen_q   <= 1'b0;
            sync_ok  <= 1'b0;
            reserved <= 1'b0;
            equipment_timing_source_level <= 1'b0;
            never_use <= 1'b0;
        end else begin
            // framed T1 carries no nibble here: quality unknown
            if (t1_mode) begin
                code_q <= ESS_Q_UNKNOWN;
                seen_q <= 1'b1;
            end else if (code_valid) begin
                code_q <= code_in;
                seen_q <= 1'b1;
            end
            sync_ok   <= accept;
            reserved  <= seen_q && rsv;
            equipment_timing_source_level <= seen_q && code_q == ESS_Q_ETS;
            never_use <= seen_q && dnu;
        end
    end
endmodule

// [ess_sync_input_qualifier.sv]
// sync input card: input qualification and line output slot 0
`timescale 1ns/10ps

module ess_sync_input_qualifier
    import ess_pkg::*;
#(
    parameter int GATE_CYCLES = ess_pkg::ESS_GATE_CYCLES
)
(
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          cfg_wr,
    input  wire logic [23:0]   cfg_freq_hz,
    input  wire logic [2:0]    cfg_slip_half,
    input  wire logic [3:0]    cfg_sa_sel,
    input  wire logic [3:0]    cfg_max_code,
    input  wire logic          cfg_in4_t1,
    input  wire logic          cfg_out_t1,
    output logic               cfg_reject,
    output logic [23:0]        freq_hz,
    output logic [2:0]         slip_half,
    output logic [3:0]         sa_sel,
    output logic [3:0]         worst_acceptable_quality_code,
    input  wire logic          pps_in_pin,
    output logic               pps_tick,
    input  wire logic          freq_in2_pin,
    input  wire logic          freq_in3_pin,
    output logic               freq2_ok,
    output logic               freq3_ok,
    output logic               freq2_lost,
    output logic               freq3_lost,
    input  wire logic          rx_ts0_valid,
    input  wire logic [7:0]    rx_ts0_byte,
    input  wire logic          rx_nfas,
    input  wire logic          rx_smf_start,
    output logic [3:0]         rx_code,
    output logic               in4_sync_ok,
    output logic               in4_reserved,
    output logic               equipment_timing_source_level,
    output logic               in4_never_use,
    input  wire logic          tx_ts0_req,
    input  wire logic          tx_nfas,
    input  wire logic          tx_smf_start,
    input  wire logic [3:0]    tx_code,
    input  wire logic          tx_si,
    input  wire logic          tx_alarm,
    output logic [7:0]         tx_ts0_byte,
    output logic               out_t1_mode,
    output logic [5:0]         out_channels,
    output logic [1:0]         out_reserved_ch,
    output logic [6:0]         out_ch_kbps,
    output logic [11:0]        out_rate_kbps
);
    logic [2:0]  pps_sync_q;
    logic [1:0]  fa_q, fb_q, fc_q;
    logic [31:0] gate_q;
    logic [23:0] cnt2_q, cnt3_q;
    logic [1:0]  tx_cnt_q;
    logic [3:0]  ext_code;
    logic        ext_valid;

    // configuration: frequency, slip and spare bit each checked on its own; the quality limit is not checked
    wire freq_in_range = cfg_freq_hz >= ESS_FREQ_MIN &&
                         cfg_freq_hz <= ESS_FREQ_MAX;
    wire slip_in_range = cfg_slip_half >= ESS_SLIP_MIN &&
                         cfg_slip_half <= ESS_SLIP_MAX;
    wire sa_in_range   = cfg_sa_sel >= ESS_SA_FIRST &&
                         cfg_sa_sel <= ESS_SA_LAST;
    wire any_bad       = !freq_in_range || !slip_in_range ||
                         !sa_in_range;

    // out of range fields keep their old value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            freq_hz    <= ESS_FREQ_DEF;
            slip_half  <= ESS_SLIP_DEF;
            sa_sel     <= ESS_SA_DEF;
            worst_acceptable_quality_code <= ESS_MAX_DEF;
            cfg_reject <= 1'b0;
        end else begin
            cfg_reject <= cfg_wr && any_bad;
            if (cfg_wr && freq_in_range)
                freq_hz <= cfg_freq_hz;
            if (cfg_wr && slip_in_range)
                slip_half <= cfg_slip_half;
            if (cfg_wr && sa_in_range)
                sa_sel <= cfg_sa_sel;
            if (cfg_wr)
                worst_acceptable_quality_code <= cfg_max_code;
        end
    end

    // byte position of the selected spare bit
    wire [2:0] sa_idx = ess_sa_index(sa_sel);

    // input one: second pulse only, synchronised then edge found
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pps_sync_q <= 3'h0;
            pps_tick   <= 1'b0;
        end else begin
            pps_sync_q <= {pps_sync_q[1:0], pps_in_pin};
            pps_tick   <= pps_sync_q[1] && !pps_sync_q[2];
        end
    end

    // inputs two and three: edge count over one gate window
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fa_q <= 2'h0;
            fb_q <= 2'h0;
            fc_q <= 2'h0;
        end else begin
            fa_q <= {freq_in3_pin, freq_in2_pin};
            fb_q <= fa_q;
            fc_q <= fb_q;
        end
    end

    // rising edges, read only from the second stage onward
    wire [1:0] fedge    = fb_q & ~fc_q;
    wire       gate_end = gate_q == 32'(GATE_CYCLES - 1);
    wire [23:0] sat     = 24'hffffff;

    // allowed deviation: twice the difference within half cycles
    wire [24:0] slip25  = 25'(slip_half);
    wire [23:0] d2      = ess_absdiff(cnt2_q, freq_hz);
    wire [23:0] d3      = ess_absdiff(cnt3_q, freq_hz);
    wire        in2_ok  = {d2, 1'b0} <= slip25;
    wire        in3_ok  = {d3, 1'b0} <= slip25;

    // window counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            gate_q <= 32'h0;
        else if (gate_end)
            gate_q <= 32'h0;
        else
            gate_q <= gate_q + 32'h1;
    end

    // edge counters, restarted at the window end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt2_q <= 24'h0;
            cnt3_q <= 24'h0;
        end else if (gate_end) begin
            cnt2_q <= 24'h0;
            cnt3_q <= 24'h0;
        end else begin
            if (fedge[0] && cnt2_q != sat)
                cnt2_q <= cnt2_q + 24'h1;
            if (fedge[1] && cnt3_q != sat)
                cnt3_q <= cnt3_q + 24'h1;
        end
    end

    // verdicts held until the next window end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            freq2_ok   <= 1'b0;
            freq3_ok   <= 1'b0;
            freq2_lost <= 1'b0;
            freq3_lost <= 1'b0;
        end else if (gate_end) begin
            freq2_ok   <= in2_ok && cnt2_q != 24'h0;
            freq3_ok   <= in3_ok && cnt3_q != 24'h0;
            freq2_lost <= cnt2_q == 24'h0;
            freq3_lost <= cnt3_q == 24'h0;
        end
    end

    // input four: framed E1 or T1, quality nibble on E1 only
    ess_ssm_extract u_extract (
        .clk        (clk),
        .rstn       (rstn),
        .enable     (!cfg_in4_t1),
        .sa_index   (sa_idx),
        .ts0_valid  (rx_ts0_valid),
        .ts0_byte   (rx_ts0_byte),
        .nfas       (rx_nfas),
        .smf_start  (rx_smf_start),
        .code       (ext_code),
        .code_valid (ext_valid)
    );

    // limit compare, reserved and never-use screening
    ess_ssm_judge u_judge (
        .clk        (clk),
        .rstn       (rstn),
        .t1_mode    (cfg_in4_t1),
        .code_in    (ext_code),
        .code_valid (ext_valid),
        .max_code   (worst_acceptable_quality_code),
        .code_q     (rx_code),
        .sync_ok    (in4_sync_ok),
        .reserved   (in4_reserved),
        .equipment_timing_source_level
                    (equipment_timing_source_level),
        .never_use  (in4_never_use)
    );

    // line outputs: slot 0 builder for E1 mode
    // nibble bit for this non-alignment frame, msb first
    wire [1:0] tx_pos  = ESS_NFAS_LAST - tx_cnt_q;
    wire       tx_bit  = tx_code[tx_pos];

    // spare field: all ones, selected bit carries the nibble
    wire [4:0] sa_mask = 5'(5'h1 << sa_idx);
    wire [4:0] sa_field = tx_bit ? ESS_SA_IDLE
                                 : (ESS_SA_IDLE & ~sa_mask);
    wire [7:0] nfas_byte = {tx_si, 1'b1, tx_alarm, sa_field};
    wire [7:0] fas_byte  = {tx_si, ESS_FAS_WORD};

    // non-alignment frame counter within the sub-multiframe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            tx_cnt_q <= 2'h0;
        else if (tx_ts0_req && tx_smf_start)
            tx_cnt_q <= 2'h0;
        else if (tx_ts0_req && tx_nfas)
            tx_cnt_q <= tx_cnt_q + 2'h1;
    end

    // slot 0 byte; in T1 mode the line carries all ones
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            tx_ts0_byte <= 8'hff;
        else if (out_t1_mode)
            tx_ts0_byte <= 8'hff;
        else if (tx_ts0_req)
            tx_ts0_byte <= tx_nfas ? nfas_byte : fas_byte;
    end

    // common output mode and its channel plan
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_t1_mode     <= 1'b0;
            out_channels    <= ESS_E1_CHANNELS;
            out_reserved_ch <= ESS_E1_RSV_CH;
            out_ch_kbps     <= ESS_CH_KBPS;
            out_rate_kbps   <= ESS_E1_KBPS;
        end else begin
            out_t1_mode     <= cfg_out_t1;
            out_ch_kbps     <= ESS_CH_KBPS;
            if (cfg_out_t1) begin
                out_channels    <= ESS_T1_CHANNELS;
                out_reserved_ch <= ESS_T1_RSV_CH;
                out_rate_kbps   <= ESS_T1_KBPS;
            end else begin
                out_channels    <= ESS_E1_CHANNELS;
                out_reserved_ch <= ESS_E1_RSV_CH;
                out_rate_kbps   <= ESS_E1_KBPS;
            end
        end
    end
endmodule

// [ess_qual_monitor.sv]
// port assertions for the sync input qualifier
`timescale 1ns/10ps
module ess_qual_monitor
    import ess_pkg::*;
#(
    parameter int GATE_CYCLES = ESS_GATE_CYCLES
)
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        cfg_wr,
    input wire logic [23:0] cfg_freq_hz,
    input wire logic [2:0]  cfg_slip_half,
    input wire logic [3:0]  cfg_sa_sel,
    input wire logic        cfg_out_t1,
    input wire logic        cfg_reject,
    input wire logic [23:0] freq_hz,
    input wire logic [2:0]  slip_half,
    input wire logic [3:0]  sa_sel,
    input wire logic [3:0]  worst_acceptable_quality_code,
    input wire logic        pps_in_pin,
    input wire logic        pps_tick,
    input wire logic [3:0]  rx_code,
    input wire logic        in4_sync_ok,
    input wire logic        in4_reserved,
    input wire logic        equipment_timing_source_level,
    input wire logic        in4_never_use,
    input wire logic        tx_ts0_req,
    input wire logic        tx_nfas,
    input wire logic [7:0]  tx_ts0_byte,
    input wire logic        out_t1_mode,
    input wire logic [5:0]  out_channels,
    input wire logic [1:0]  out_reserved_ch,
    input wire logic [11:0] out_rate_kbps
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // configuration defaults and refusals
    a_reset_defaults: assert property (
        $rose(rstn) |-> sa_sel == ESS_SA_DEF && freq_hz == ESS_FREQ_DEF
        && slip_half == ESS_SLIP_DEF) else $error("bad reset defaults");
    a_sa_refuse: assert property (
        cfg_wr && (cfg_sa_sel < ESS_SA_FIRST || cfg_sa_sel > ESS_SA_LAST)
        |=> cfg_reject && sa_sel == $past(sa_sel))
        else $error("bad spare bit choice taken");
    a_sa_load: assert property (
        cfg_wr && cfg_sa_sel inside {[ESS_SA_FIRST:ESS_SA_LAST]}
        |=> sa_sel == $past(cfg_sa_sel)) else $error("spare bit not loaded");
    a_freq_refuse: assert property (
        cfg_wr && (cfg_freq_hz < ESS_FREQ_MIN || cfg_freq_hz > ESS_FREQ_MAX)
        |=> cfg_reject && freq_hz == $past(freq_hz))
        else $error("bad frequency taken");
    a_slip_refuse: assert property (
        cfg_wr && (cfg_slip_half < ESS_SLIP_MIN || cfg_slip_half > 3'h6)
        |=> cfg_reject && slip_half == $past(slip_half))
        else $error("bad slip tolerance taken");

    // quality judgement follows the held code and limit
    a_sync_excl: assert property (
        in4_sync_ok |-> !in4_never_use && !in4_reserved
        && $past(rx_code) <= $past(worst_acceptable_quality_code))
        else $error("unusable source marked usable");
    a_ets_flag: assert property (
        equipment_timing_source_level == ($past(rx_code) == 4'hb))
        else $error("equipment timing flag wrong");
    a_never_flag: assert property (
        in4_never_use == ($past(rx_code) == 4'hf))
        else $error("never use flag wrong");

    // pps tick is one cycle wide, a few cycles after the pin
    a_pps_tick: assert property (
        $rose(pps_in_pin) |-> ##[2:4] pps_tick ##1 !pps_tick)
        else $error("pps tick missing or long");

    // transmitted spare bits other than the chosen one are ones
    a_tx_spare: assert property (
        tx_ts0_req && tx_nfas |=> tx_ts0_byte[6] && 5'h1f ==
        (tx_ts0_byte[4:0] | (5'h10 >> ($past(sa_sel) - 4'h4))))
        else $error("idle spare bit not one");
    a_out_mode: assert property (
        out_t1_mode == $past(cfg_out_t1) && out_channels ==
        (out_t1_mode ? 6'h18 : 6'h20) && out_reserved_ch ==
        (out_t1_mode ? 2'h0 : 2'h2) && out_rate_kbps ==
        (out_t1_mode ? 12'h608 : 12'h800)) else $error("line mode wrong");

    c_reject: cover property (cfg_reject);
    c_never: cover property (in4_never_use);
    c_t1_tx: cover property (out_t1_mode && tx_ts0_req);
endmodule

// [ess_line_partner.sv]
// line equipment model sending slot 0 frames with a quality nibble
`timescale 1ns/10ps
module ess_line_partner (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [3:0] code,
    input  wire logic [3:0] sa,
    output logic            valid,
    output logic [7:0]      ts0,
    output logic            nfas,
    output logic            smf
);
    int f;
    // one sub-multiframe: smf fas frame, then nfas and fas frames in turn
    initial begin
        {valid, nfas, smf} = 3'h0;
        ts0 = 8'h5a;
        forever begin
            @(posedge clk);
            if (go) begin
                for (f = 0; f < 8; f++) begin
                    #1;
                    valid = 1'b1;
                    smf = (f == 0);
                    nfas = f[0];
                    ts0 = {1'b1, 7'h1b};
                    if (f[0]) begin
                        ts0 = 8'hdf;
                        ts0[4'h8 - sa] = code[3 - (f >> 1)];
                    end
                    @(posedge clk);
                end
                #1;
                {valid, nfas, smf} = 3'h0;
                ts0 = ~ts0; // released byte is not left holding
            end
        end
    end
endmodule

// [ess_sync_input_qualifier_tb_top.sv]
// self-checking bench for the sync input qualifier
`timescale 1ns/10ps
module ess_sync_input_qualifier_tb_top;
    import ess_pkg::*;
    localparam int GATE = 8000;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cfg_wr, cfg_in4_t1, cfg_out_t1, cfg_reject, go;
    logic [23:0] cfg_freq_hz, freq_hz;
    logic [2:0]  cfg_slip_half, slip_half;
    logic [3:0]  cfg_sa_sel, cfg_max_code, sa_sel, p_code;
    logic [3:0]  worst_acceptable_quality_code, rx_code, tx_code;
    logic        pps_in_pin, pps_tick, freq_in2_pin, freq_in3_pin;
    logic        freq2_ok, freq3_ok, freq2_lost, freq3_lost;
    logic        rx_ts0_valid, rx_nfas, rx_smf_start, in4_sync_ok;
    logic        in4_reserved, equipment_timing_source_level;
    logic        in4_never_use, tx_ts0_req, tx_nfas, tx_smf_start;
    logic        tx_si, tx_alarm, out_t1_mode;
    logic [7:0]  rx_ts0_byte, tx_ts0_byte, e;
    logic [5:0]  out_channels;
    logic [1:0]  out_reserved_ch;
    logic [6:0]  out_ch_kbps;
    logic [11:0] out_rate_kbps;
    int unsigned seed;
    int          err_total, check_count, c, k, m, n, mf, ms, mz;

    ess_sync_input_qualifier #(.GATE_CYCLES(GATE)) dut (.*);
    ess_line_partner u_line (.clk(clk), .go(go), .code(p_code),
        .sa(cfg_sa_sel), .valid(rx_ts0_valid), .ts0(rx_ts0_byte),
        .nfas(rx_nfas), .smf(rx_smf_start));

    // clock, and 1000 rising edges per gate on input two
    always #10 clk = ~clk;
    always begin
        repeat (4) @(posedge clk);
        #1 freq_in2_pin = ~freq_in2_pin;
    end

    task automatic tick(input int t);
        repeat (t) @(posedge clk);
        #1;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] ex);
        check_count++;
        if (got !== ex) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask
    task automatic chk_flag(input logic got, input logic ex);
        chk_val({31'h0, got}, {31'h0, ex});
    endtask
    function automatic int unsigned xs(input int unsigned x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // config write with its own model of range checks
    task automatic cfg(input int f, input int sl, input int sa, input int mx);
        logic bad;
        bad = f < 1000 || f > 10000000 || sl < 1 || sl > 6 || sa < 4 || sa > 8;
        if (f >= 1000 && f <= 10000000) mf = f;
        if (sl >= 1 && sl <= 6) ms = sl;
        if (sa >= 4 && sa <= 8) mz = sa;
        {cfg_freq_hz, cfg_slip_half} = {f[23:0], sl[2:0]};
        {cfg_sa_sel, cfg_max_code} = {sa[3:0], mx[3:0]};
        cfg_wr = 1'b1;
        tick(1);
        cfg_wr = 1'b0;
        chk_flag(cfg_reject, bad);
        chk_val(freq_hz, mf);
        chk_val(slip_half, ms);
        chk_val(sa_sel, mz);
        chk_val(worst_acceptable_quality_code, mx);
        tick(1);
    endtask
    task automatic tx_send(input logic nf, input logic sm,
                           input logic [7:0] x);
        {tx_nfas, tx_smf_start, tx_ts0_req} = {nf, sm, 1'b1};
        tick(1);
        tx_ts0_req = 1'b0;
        chk_val(tx_ts0_byte, x);
        tick(1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // main sequence
    initial begin
        {cfg_wr, cfg_in4_t1, cfg_out_t1, pps_in_pin, go} = '0;
        {freq_in2_pin, freq_in3_pin, tx_ts0_req, tx_nfas} = '0;
        {tx_smf_start, tx_si, tx_alarm, tx_code, p_code} = '0;
        {cfg_freq_hz, cfg_slip_half, cfg_sa_sel, cfg_max_code} = '0;
        {err_total, check_count, mf, ms, mz} = {32'd0, 32'd0, 32'd2048000,
            32'd3, 32'd4};
        seed = 18266;
        tick(8);
        rstn = 1'b1;
        chk_val(sa_sel, 4);
        chk_val(freq_hz, 2048000);
        chk_val(slip_half, 3);
        // refused fields keep old values, others still load
        cfg(999, 0, 3, 8);
        cfg(10000001, 7, 9, 8);
        cfg(10000000, 6, 8, 8);
        cfg(999, 1, 4, 8);
        // every quality code through a rotating spare bit
        for (c = 0; c < 16; c++) begin
            seed = xs(seed);
            m = (c == 15) ? 15 : int'(seed % 16);
            cfg(1000, 3, 4 + c % 5, m);
            p_code = c[3:0];
            go = 1'b1;
            tick(1);
            go = 1'b0;
            tick(13);
            n = (c inside {0, 2, 4, 8, 11}) && c <= m;
            chk_val(rx_code, c);
            chk_flag(in4_sync_ok, n[0]);
            chk_flag(in4_reserved, !(c inside {0, 2, 4, 8, 11, 15}));
            chk_flag(equipment_timing_source_level, c == 11);
            chk_flag(in4_never_use, c == 15);
        end
        // t1 framed input: unknown quality accepted
        cfg_in4_t1 = 1'b1;
        tick(4);
        chk_val(rx_code, 0);
        chk_flag(in4_sync_ok, 1'b1);
        cfg_in4_t1 = 1'b0;
        // transmitted slot 0 with each spare bit choice
        for (m = 4; m <= 8; m++) begin
            cfg(1000, 3, m, 8);
            seed = xs(seed);
            {tx_alarm, tx_si, tx_code} = seed[5:0];
            tx_send(1'b0, 1'b1, {tx_si, 7'h1b});
            for (k = 0; k < 4; k++) begin
                e = {tx_si, 1'b1, tx_alarm, 5'h1f};
                e[8 - m] = tx_code[3 - k];
                tx_send(1'b1, 1'b0, e);
            end
        end
        // line output mode t1 then back to e1
        for (k = 1; k >= 0; k--) begin
            cfg_out_t1 = k[0];
            tick(2);
            chk_val(out_channels, k ? 24 : 32);
            chk_flag(out_t1_mode, k[0]);
            chk_val(out_reserved_ch, k ? 0 : 2);
            chk_val(out_ch_kbps, 64);
            chk_val(out_rate_kbps, k ? 1544 : 2048);
            if (k == 1)
                tx_send(1'b1, 1'b0, 8'hff);
        end
        // one pps pulse gives one tick, bounded wait
        pps_in_pin = 1'b1;
        n = 0;
        for (k = 0; k < 10; k++) begin
            tick(1);
            if (k == 2)
                pps_in_pin = 1'b0;
            n += pps_tick;
        end
        chk_val(n, 1);
        if (n == 0)
            tally_and_finish();
        // two full gates at 1000 edges with tolerance 1.5
        tick(2 * GATE);
        chk_flag(freq2_ok, 1'b1);
        chk_flag(freq2_lost, 1'b0);
        chk_flag(freq3_ok, 1'b0);
        chk_flag(freq3_lost, 1'b1);
        tally_and_finish();
    end
endmodule

bind ess_sync_input_qualifier ess_qual_monitor
    #(.GATE_CYCLES(GATE_CYCLES)) u_mon (.*);
